// File: common/lado_pkg.sv
// shared constants, types and decode functions for the link ordering block
package lado_pkg;

  // ==========================================================================
  // widths
  localparam int ADDR_W = 40;
  localparam int DATA_W = 32;
  localparam int LEN_W  = 4;
  localparam int SEQ_W  = 4;
  localparam int SRC_W  = 5;
  localparam int SNAP_W = 3;
  localparam int ALIGN_BITS = 6;
  localparam int FIFO_DEPTH = 4;

  // ==========================================================================
  // address map, region bases in ascending order
  localparam logic [ADDR_W-1:0] INTR_BASE  = 40'hfd_0000_0000;
  localparam logic [ADDR_W-1:0] LEGACY_INTR_ACKNOWLEDGE_BASE  = 40'hfd_f900_0000;
  localparam logic [ADDR_W-1:0] SMGT_BASE  = 40'hfd_f910_0000;
  localparam logic [ADDR_W-1:0] RSV_BASE   = 40'hfd_f920_0000;
  localparam logic [ADDR_W-1:0] IO_BASE    = 40'hfd_fc00_0000;
  localparam logic [ADDR_W-1:0] CFG_BASE   = 40'hfd_fe00_0000;
  localparam logic [ADDR_W-1:0] RSVHI_BASE = 40'hfe_0000_0000;
  localparam logic [ADDR_W-1:0] SPACE_32MB = 40'h00_0200_0000;
  localparam logic [7:0]        INTR_MARK  = 8'hf8;
  localparam int                INTR_MARK_LSB = 24;
  localparam logic [LEN_W-1:0]  LEN_ONE_DW = 4'h0;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    LADO_CMD_PWR, LADO_CMD_NPWR, LADO_CMD_RD, LADO_CMD_BCAST,
    LADO_CMD_FENCE, LADO_CMD_RSP
  } lado_cmd_t;

  typedef enum logic [1:0] {LADO_VC_POSTED, LADO_VC_NONPOST, LADO_VC_RESP}
    lado_vc_t;

  typedef enum logic [2:0] {
    LADO_RGN_MEM, LADO_RGN_INTR, LADO_RGN_LEGACY_INTR_ACKNOWLEDGE, LADO_RGN_SMGT,
    LADO_RGN_RSV, LADO_RGN_IO, LADO_RGN_CFG
  } lado_rgn_t;

  typedef struct packed {
    lado_cmd_t                  cmd;
    logic [ADDR_W-1:0]          addr;
    logic [LEN_W-1:0]           len;
    logic [SEQ_W-1:0]           sequence_tag;
    logic                       may_overtake_posted_flag;
    logic [SRC_W-1:0]           src;
    logic [DATA_W-1:0]          data;
  } lado_pkt_t;

  typedef struct packed {
    logic                       err;
    logic [SRC_W-1:0]           src;
    logic [DATA_W-1:0]          data;
  } lado_rsp_t;

  typedef struct packed {
    lado_pkt_t                  pkt;
    lado_rgn_t                  rgn;
    logic [SNAP_W-1:0]          snap;
    logic                       bad;
  } lado_ent_t;

  // ==========================================================================
  // full-width region decode, bases compared top down
  function automatic lado_rgn_t lado_decode(input logic [ADDR_W-1:0] a);
    if (a >= RSVHI_BASE) return LADO_RGN_RSV;
    else if (a >= CFG_BASE) return LADO_RGN_CFG;
    else if (a >= IO_BASE) return LADO_RGN_IO;
    else if (a >= RSV_BASE) return LADO_RGN_RSV;
    else if (a >= SMGT_BASE) return LADO_RGN_SMGT;
    else if (a >= LEGACY_INTR_ACKNOWLEDGE_BASE) return LADO_RGN_LEGACY_INTR_ACKNOWLEDGE;
    else if (a >= INTR_BASE) return LADO_RGN_INTR;
    else return LADO_RGN_MEM;
  endfunction

  // virtual channel from command encoding
  function automatic lado_vc_t lado_vc(input lado_cmd_t c);
    case (c)
      LADO_CMD_NPWR, LADO_CMD_RD: return LADO_VC_NONPOST;
      LADO_CMD_RSP:               return LADO_VC_RESP;
      default:                    return LADO_VC_POSTED;
    endcase
  endfunction

endpackage

// File: common/lado_link_if.sv
// link between requester end and ordering node end
`timescale 1ns/100ps
interface lado_link_if;
  logic                pkt_valid;
  logic                pkt_ready;
  lado_pkg::lado_pkt_t pkt;
  logic                rsp_valid;
  logic                rsp_ready;
  lado_pkg::lado_rsp_t rsp;

  modport requester (
    output pkt_valid, pkt, rsp_ready,
    input  pkt_ready, rsp_valid, rsp
  );
  modport node (
    input  pkt_valid, pkt, rsp_ready,
    output pkt_ready, rsp_valid, rsp
  );
endinterface

// File: rtl/lado_node.sv
// ordering node end: address decode, per-channel buffering, ordering
`timescale 1ns/100ps

// ============================================================================
// simple synchronous fifo, depth a power of two
module lado_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  logic             full;
  logic             empty;

  // extra pointer bit tells full from empty
  assign full      = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty     = (wp_r == rp_r);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp_r[AW-1:0]];

  // write pointer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) wp_r <= '0;
    else if (in_valid && !full) wp_r <= wp_r + (AW+1)'(1);
  end

  // read pointer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rp_r <= '0;
    else if (out_ready && !empty) rp_r <= rp_r + (AW+1)'(1);
  end

  // storage, no reset needed for data
  always_ff @(posedge clk) begin
    if (in_valid && !full) mem[wp_r[AW-1:0]] <= in_data;
  end
endmodule

// ============================================================================
// node end
module lado_node #(
  parameter logic [lado_pkg::ADDR_W-1:0] WIN_BASE  = 40'h00_0000_0000,
  parameter logic [lado_pkg::ADDR_W-1:0] WIN_LIMIT = 40'h00_ffff_ffff,
  parameter int                          DEPTH     = lado_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RST_B,
  // link toward requester
  lado_link_if.node                          LINK,
  // delivery to local logic
  output logic                               OUT_VALID,
  input  wire logic                          OUT_READY,
  output lado_pkg::lado_pkt_t                OUT_PKT,
  output lado_pkg::lado_rgn_t                OUT_RGN,
  output logic                               OUT_CLAIM,
  // completion of delivered nonposted request
  input  wire logic                          GLOBALLY_VISIBLE_POINT,
  input  wire logic [lado_pkg::DATA_W-1:0]   DONE_DATA,
  // status
  output logic                               NP_WAIT,
  output logic                               DROP_PULSE
);
  localparam int NVC = 3;
  localparam int EW  = $bits(lado_pkg::lado_ent_t);
  localparam logic [lado_pkg::ADDR_W-1:0] ALIGN_MASK =
    ~((lado_pkg::ADDR_W)'(1 << lado_pkg::ALIGN_BITS) - 40'h00_0000_0001);

  lado_pkg::lado_ent_t         ent_in;
  lado_pkg::lado_vc_t          vc_in;
  lado_pkg::lado_rgn_t         rgn_in;
  lado_pkg::lado_ent_t         head [NVC];
  logic [NVC-1:0]              f_in_vld;
  logic [NVC-1:0]              f_in_rdy;
  logic [NVC-1:0]              f_out_vld;
  logic [NVC-1:0]              f_pop;
  logic [EW-1:0]               f_out_data [NVC];
  logic [lado_pkg::SNAP_W-1:0] penq_r;
  logic [lado_pkg::SNAP_W-1:0] pdeq_r;
  logic                        out_free;
  logic                        np_busy;
  logic                        p_ok;
  logic                        r_ok;
  logic                        n_ok;
  logic                        r_fast;
  logic                        np_wait_r;
  logic [lado_pkg::SRC_W-1:0]  np_src_r;
  logic                        rsp_vld_r;
  lado_pkg::lado_rsp_t         rsp_r;
  logic                        out_vld_r;
  lado_pkg::lado_pkt_t         out_pkt_r;
  lado_pkg::lado_rgn_t         out_rgn_r;
  logic                        out_claim_r;
  logic                        drop_r;
  logic                        win_hit;
  lado_pkg::lado_ent_t         sel;

  // ==========================================================================
  // classify incoming packet in one cycle
  assign vc_in  = lado_pkg::lado_vc(LINK.pkt.cmd);
  assign rgn_in = lado_pkg::lado_decode(LINK.pkt.addr);
  always_comb begin
    ent_in      = '0;
    ent_in.pkt  = LINK.pkt;
    ent_in.rgn  = rgn_in;
    ent_in.snap = penq_r;
    if (vc_in != lado_pkg::LADO_VC_RESP) begin
      // reserved space has no target on this node
      ent_in.bad = (rgn_in == lado_pkg::LADO_RGN_RSV);
      // long nonposted cfg/io accesses aborted rather than split
      if (vc_in == lado_pkg::LADO_VC_NONPOST &&
          (rgn_in == lado_pkg::LADO_RGN_IO ||
           rgn_in == lado_pkg::LADO_RGN_CFG) &&
          LINK.pkt.len != lado_pkg::LEN_ONE_DW)
        ent_in.bad = 1'b1;
    end
  end

  // stall only the channel the packet belongs to
  assign LINK.pkt_ready = f_in_rdy[vc_in];

  // ==========================================================================
  // one buffer per channel; fifo order holds tag sequences and issue order
  for (genvar v = 0; v < NVC; v++) begin : g_vc
    assign f_in_vld[v] = LINK.pkt_valid && (vc_in == v);
    assign head[v]     = lado_pkg::lado_ent_t'(f_out_data[v]);
    lado_fifo #(.WIDTH(EW), .DEPTH(DEPTH)) u_fifo (
      .clk       (CLK),
      .rst_b     (RST_B),
      .in_valid  (f_in_vld[v]),
      .in_ready  (f_in_rdy[v]),
      .in_data   (ent_in),
      .out_valid (f_out_vld[v]),
      .out_ready (f_pop[v]),
      .out_data  (f_out_data[v])
    );
  end

  // posted enqueue / dequeue counts mark what is still ahead
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) penq_r <= '0;
    else if (f_in_vld[lado_pkg::LADO_VC_POSTED] &&
             f_in_rdy[lado_pkg::LADO_VC_POSTED])
      penq_r <= penq_r + (lado_pkg::SNAP_W)'(1);
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) pdeq_r <= '0;
    else if (f_pop[lado_pkg::LADO_VC_POSTED])
      pdeq_r <= pdeq_r + (lado_pkg::SNAP_W)'(1);
  end

  // ==========================================================================
  // arbitration; single stream assumed, conservative across sources
  assign out_free = !out_vld_r || OUT_READY;
  assign np_busy  = np_wait_r || rsp_vld_r;
  // flag clear waits until every earlier posted request left
  assign p_ok  = f_out_vld[lado_pkg::LADO_VC_POSTED];
  assign r_ok  = f_out_vld[lado_pkg::LADO_VC_RESP] &&
                 (head[lado_pkg::LADO_VC_RESP].pkt.may_overtake_posted_flag ||
                  head[lado_pkg::LADO_VC_RESP].snap == pdeq_r);
  assign n_ok  = f_out_vld[lado_pkg::LADO_VC_NONPOST] && !np_busy &&
                 (head[lado_pkg::LADO_VC_NONPOST].pkt.may_overtake_posted_flag
                  || head[lado_pkg::LADO_VC_NONPOST].snap == pdeq_r);
  assign r_fast = r_ok &&
                  head[lado_pkg::LADO_VC_RESP].pkt.may_overtake_posted_flag;

  // flagged responses first, then posted, responses, nonposted
  always_comb begin
    f_pop = '0;
    if (out_free) begin
      if (r_fast) f_pop[lado_pkg::LADO_VC_RESP] = 1'b1;
      else if (p_ok) f_pop[lado_pkg::LADO_VC_POSTED] = 1'b1;
      else if (r_ok) f_pop[lado_pkg::LADO_VC_RESP] = 1'b1;
      else if (n_ok) f_pop[lado_pkg::LADO_VC_NONPOST] = 1'b1;
    end
  end

  always_comb begin
    sel = '0;
    if (f_pop[lado_pkg::LADO_VC_RESP]) sel = head[lado_pkg::LADO_VC_RESP];
    else if (f_pop[lado_pkg::LADO_VC_POSTED])
      sel = head[lado_pkg::LADO_VC_POSTED];
    else if (f_pop[lado_pkg::LADO_VC_NONPOST])
      sel = head[lado_pkg::LADO_VC_NONPOST];
  end

  // window aligned to 64 bytes; outside it the packet travels upstream
  assign win_hit = (sel.pkt.addr >= (WIN_BASE & ALIGN_MASK)) &&
                   (sel.pkt.addr <= (WIN_LIMIT | ~ALIGN_MASK)) &&
                   (sel.rgn == lado_pkg::LADO_RGN_MEM);

  // ==========================================================================
  // delivery register; targetless requests never reach local logic
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      out_vld_r   <= 1'b0;
      out_pkt_r   <= '0;
      out_rgn_r   <= lado_pkg::LADO_RGN_MEM;
      out_claim_r <= 1'b0;
    end else if (out_free) begin
      out_vld_r <= (|f_pop) && !sel.bad;
      if (|f_pop) begin
        out_pkt_r   <= sel.pkt;
        out_rgn_r   <= sel.rgn;
        // special ranges are passed on, never claimed here
        out_claim_r <= win_hit;
      end
    end
  end

  // targetless posted drops or aborted nonposted show as a pulse
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) drop_r <= 1'b0;
    else drop_r <= (|f_pop) && sel.bad;
  end

  // one nonposted at a time in local logic keeps completion order
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      np_wait_r <= 1'b0;
      np_src_r  <= '0;
    end else if (f_pop[lado_pkg::LADO_VC_NONPOST]) begin
      np_wait_r <= !sel.bad;
      np_src_r  <= sel.pkt.src;
    end else if (GLOBALLY_VISIBLE_POINT) begin
      np_wait_r <= 1'b0;
    end
  end

  // ==========================================================================
  // response out; single slot suffices with one nonposted in flight
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rsp_vld_r <= 1'b0;
      rsp_r     <= '0;
    end else if (np_wait_r && GLOBALLY_VISIBLE_POINT) begin
      rsp_vld_r <= 1'b1;
      rsp_r     <= '{err: 1'b0, src: np_src_r, data: DONE_DATA};
    end else if (f_pop[lado_pkg::LADO_VC_NONPOST] && sel.bad) begin
      rsp_vld_r <= 1'b1;
      rsp_r     <= '{err: 1'b1, src: sel.pkt.src, data: '0};
    end else if (LINK.rsp_ready) begin
      rsp_vld_r <= 1'b0;
    end
  end

  assign LINK.rsp_valid = rsp_vld_r;
  assign LINK.rsp       = rsp_r;
  assign OUT_VALID      = out_vld_r;
  assign OUT_PKT        = out_pkt_r;
  assign OUT_RGN        = out_rgn_r;
  assign OUT_CLAIM      = out_claim_r;
  assign NP_WAIT        = np_wait_r;
  assign DROP_PULSE     = drop_r;
endmodule

// File: rtl/lado_requester.sv
// requester end: legality screening, interrupt marking, issue of packets
`timescale 1ns/100ps
module lado_requester (
  // clock and reset
  input  wire logic                        CLK,
  input  wire logic                        RST_B,
  // local request port
  input  wire logic                        REQ_VALID,
  output logic                             REQ_READY,
  input  wire lado_pkg::lado_pkt_t         REQ_PKT,
  output logic                             REQ_REFUSED,
  // local response port
  output logic                             RSP_VALID,
  output lado_pkg::lado_rsp_t              RSP,
  output logic                             NP_BUSY,
  // link toward node
  lado_link_if.requester                   LINK
);
  logic                pkt_vld_r;
  lado_pkg::lado_pkt_t pkt_r;
  logic                np_out_r;
  logic                refused_r;
  logic                rsp_vld_r;
  lado_pkg::lado_rsp_t rsp_r;
  logic                take;
  logic                illegal;
  logic                is_np;
  lado_pkg::lado_rgn_t rgn;
  lado_pkg::lado_pkt_t fixed;

  // ==========================================================================
  // screening of the request against its target space
  assign rgn   = lado_pkg::lado_decode(REQ_PKT.addr);
  assign is_np = lado_pkg::lado_vc(REQ_PKT.cmd) == lado_pkg::LADO_VC_NONPOST;
  always_comb begin
    illegal = 1'b0;
    unique case (rgn)
      lado_pkg::LADO_RGN_IO, lado_pkg::LADO_RGN_CFG:
        illegal = REQ_PKT.cmd == lado_pkg::LADO_CMD_PWR ||
                  REQ_PKT.cmd == lado_pkg::LADO_CMD_BCAST ||
                  (REQ_PKT.cmd == lado_pkg::LADO_CMD_NPWR &&
                   REQ_PKT.len != lado_pkg::LEN_ONE_DW);
      lado_pkg::LADO_RGN_INTR, lado_pkg::LADO_RGN_SMGT:
        illegal = REQ_PKT.cmd == lado_pkg::LADO_CMD_NPWR;
      // every upstream access there is undefined
      lado_pkg::LADO_RGN_LEGACY_INTR_ACKNOWLEDGE: illegal = 1'b1;
      lado_pkg::LADO_RGN_MEM, lado_pkg::LADO_RGN_RSV: illegal = 1'b0;
    endcase
    // responses are not address-screened
    if (REQ_PKT.cmd == lado_pkg::LADO_CMD_RSP) illegal = 1'b0;
  end

  // interrupts marked so every host recognises them
  always_comb begin
    fixed = REQ_PKT;
    if (rgn == lado_pkg::LADO_RGN_INTR &&
        REQ_PKT.cmd != lado_pkg::LADO_CMD_RSP)
      fixed.addr[lado_pkg::INTR_MARK_LSB +: 8] = lado_pkg::INTR_MARK;
  end

  // one nonposted outstanding, so responses cannot come out of order
  assign REQ_READY = !pkt_vld_r && !np_out_r;
  assign take      = REQ_VALID && REQ_READY;

  // ==========================================================================
  // link packet register; all traffic goes upstream, peers included
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pkt_vld_r <= 1'b0;
      pkt_r     <= '0;
    end else if (take && !illegal) begin
      pkt_vld_r <= 1'b1;
      pkt_r     <= fixed;
    end else if (LINK.pkt_ready) begin
      pkt_vld_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) refused_r <= 1'b0;
    else refused_r <= take && illegal;
  end

  // outstanding nonposted; the arriving response wins over nothing else
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) np_out_r <= 1'b0;
    else if (take && !illegal && is_np) np_out_r <= 1'b1;
    else if (LINK.rsp_valid) np_out_r <= 1'b0;
  end

  // response capture, always accepted
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rsp_vld_r <= 1'b0;
      rsp_r     <= '0;
    end else begin
      rsp_vld_r <= LINK.rsp_valid;
      if (LINK.rsp_valid) rsp_r <= LINK.rsp;
    end
  end

  assign LINK.pkt_valid = pkt_vld_r;
  assign LINK.pkt       = pkt_r;
  assign LINK.rsp_ready = 1'b1;
  assign REQ_REFUSED    = refused_r;
  assign RSP_VALID      = rsp_vld_r;
  assign RSP            = rsp_r;
  assign NP_BUSY        = np_out_r;
endmodule

// File: verification/lado_link_chk.sv
// checker: screening and handshake rules on the requester to node link
`timescale 1ns/100ps
module lado_link_chk (
  // clock and reset
  input wire logic                CLK,
  input wire logic                RST_B,
  // packet channel
  input wire logic                pkt_valid,
  input wire logic                pkt_ready,
  input wire lado_pkg::lado_pkt_t pkt,
  // response channel
  input wire logic                rsp_valid,
  input wire logic                rsp_ready,
  input wire lado_pkg::lado_rsp_t rsp
);
  // ==========================================================================
  // helpers
  logic        np_out_r;
  logic        is_np;
  logic [39:0] a;
  assign a = pkt.addr;
  assign is_np = pkt.cmd inside {lado_pkg::LADO_CMD_NPWR,
                                 lado_pkg::LADO_CMD_RD};
  // nonposted in flight, cleared when its answer is taken
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) np_out_r <= 1'b0;
    else if (pkt_valid && pkt_ready && is_np) np_out_r <= 1'b1;
    else if (rsp_valid && rsp_ready) np_out_r <= 1'b0;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // ==========================================================================
  // assertions
  pkt_hold_a: assert property (
    pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt))
    else $error("packet changed while stalled");
  iocfg_post_a: assert property (
    pkt_valid && a >= 40'hfd_fc00_0000 && a < 40'hfe_0000_0000
    |-> is_np) else $error("posted packet sent to io or cfg");
  iocfg_len_a: assert property (
    pkt_valid && a >= 40'hfd_fc00_0000 && a < 40'hfe_0000_0000
    |-> pkt.cmd != lado_pkg::LADO_CMD_NPWR || pkt.len == 4'h0)
    else $error("long nonposted write to io or cfg");
  intr_post_a: assert property (
    pkt_valid && ((a >= 40'hfd_0000_0000 && a < 40'hfd_f900_0000) ||
    (a >= 40'hfd_f910_0000 && a < 40'hfd_f920_0000))
    |-> pkt.cmd != lado_pkg::LADO_CMD_NPWR)
    else $error("nonposted write to intr or mgmt");
  legacy_intr_acknowledge_none_a: assert property (
    pkt_valid |-> !(a >= 40'hfd_f900_0000 && a < 40'hfd_f910_0000 &&
    pkt.cmd != lado_pkg::LADO_CMD_RSP)) else $error("request to ack space");
  intr_mark_a: assert property (
    pkt_valid && a >= 40'hfd_0000_0000 && a < 40'hfd_f900_0000
    |-> a[31:24] == 8'hf8) else $error("interrupt lacks f8 mark");
  np_single_a: assert property (
    np_out_r |-> !pkt_valid) else $error("second packet while np open");
  rsp_owed_a: assert property (
    rsp_valid |-> np_out_r) else $error("response with nothing open");
  rsp_once_a: assert property (
    rsp_valid && rsp_ready |=> !rsp_valid) else $error("response repeated");
  // main scenarios
  stall_c: cover property (pkt_valid && !pkt_ready);
  np_c: cover property (pkt_valid && pkt_ready && is_np);
  err_c: cover property (rsp_valid && rsp.err);
endmodule

// File: verification/testbench.sv
// self-checking bench: requester and node joined by the link interface
`timescale 1ns/100ps
module testbench;
  // ==========================================================================
  // signals and scoreboard
  logic clk = 1'b0;
  logic rst_b, req_valid, req_ready, req_refused, rsp_valid, out_valid;
  logic out_ready, out_claim, gv, drop_pulse, np_busy, np_wait;
  logic [31:0] done_data, d;
  logic [4:0] s;
  lado_pkg::lado_pkt_t req_pkt, out_pkt, q_pkt[$];
  lado_pkg::lado_rsp_t rsp_out, e, q_rsp[$];
  lado_pkg::lado_rgn_t out_rgn, q_rgn[$];
  logic q_clm[$];
  int err_count, n_compared, ref_exp, ref_got, drop_exp, drop_got, cyc;
  always #5 clk = ~clk;
  lado_link_if i_lado_link_if ();
  lado_requester i_lado_requester (
    .CLK(clk), .RST_B(rst_b), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_PKT(req_pkt), .REQ_REFUSED(req_refused), .RSP_VALID(rsp_valid),
    .RSP(rsp_out), .NP_BUSY(np_busy), .LINK(i_lado_link_if));
  lado_node i_lado_node (
    .CLK(clk), .RST_B(rst_b), .LINK(i_lado_link_if), .OUT_VALID(out_valid),
    .OUT_READY(out_ready), .OUT_PKT(out_pkt), .OUT_RGN(out_rgn),
    .OUT_CLAIM(out_claim), .GLOBALLY_VISIBLE_POINT(gv),
    .DONE_DATA(done_data), .NP_WAIT(np_wait), .DROP_PULSE(drop_pulse));
  lado_link_chk i_lado_link_chk (
    .CLK(clk), .RST_B(rst_b), .pkt_valid(i_lado_link_if.pkt_valid),
    .pkt_ready(i_lado_link_if.pkt_ready), .pkt(i_lado_link_if.pkt),
    .rsp_valid(i_lado_link_if.rsp_valid),
    .rsp_ready(i_lado_link_if.rsp_ready), .rsp(i_lado_link_if.rsp));
  // ==========================================================================
  // tasks
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // kind: 0 delivered, 1 refused, 2 dropped, 3 error answer plus drop
  task automatic go(input logic [2:0] c, input logic [39:0] a,
                    input logic [3:0] l, input int k,
                    input logic [2:0] g, input logic m);
    lado_pkg::lado_pkt_t p;
    int n;
    p = {c, a, l, 4'($urandom), 1'($urandom), 5'($urandom), $urandom};
    req_pkt <= p;
    req_valid <= 1'b1;
    if (k == 0) begin
      if (g == 3'h1) p.addr[31:24] = 8'hf8;
      q_pkt.push_back(p);
      q_rgn.push_back(lado_pkg::lado_rgn_t'(g));
      q_clm.push_back(m);
    end
    else if (k == 1) ref_exp++;
    else if (k == 2) drop_exp++;
    else begin
      // an aborted or targetless nonposted also leaves a drop pulse
      drop_exp++;
      q_rsp.push_back({1'b1, p.src, 32'h0});
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 300);
    if (n >= 300) err_count++;
  endtask
  // ==========================================================================
  // monitors: delivery, answers, pulses, hang guard
  always @(posedge clk) if (rst_b === 1'b1) begin
    if (out_valid && out_ready) begin
      if (q_pkt.size() == 0) chk(1'b1, 1'b0);
      else begin
        chk(out_pkt, q_pkt.pop_front());
        chk(out_rgn, q_rgn.pop_front());
        chk(out_claim, q_clm.pop_front());
      end
    end
    if (rsp_valid) begin
      e = q_rsp.size() ? q_rsp.pop_front() : '1;
      if (e.err) chk({rsp_out.err, rsp_out.src}, {e.err, e.src});
      else chk(rsp_out, e);
    end
    if (req_refused) ref_got++;
    if (drop_pulse) drop_got++;
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      wrap_up();
    end
  end
  // completion of a delivered read, a few cycles late on purpose
  always @(posedge clk) begin
    if (rst_b && out_valid && out_ready &&
        out_pkt.cmd == lado_pkg::LADO_CMD_RD) begin
      s = out_pkt.src;
      repeat (2) @(posedge clk);
      chk({np_busy, np_wait}, 2'b11);
      d = $urandom;
      done_data <= d;
      gv <= 1'b1;
      q_rsp.push_back({1'b0, s, d});
      @(posedge clk);
      gv <= 1'b0;
    end
  end
  // ==========================================================================
  // main sequence; cmd 0 pwr 1 npwr 2 rd 3 bcast 4 fence 5 rsp; rgn as pkg
  initial begin
    void'($urandom(13917));
    {rst_b, req_valid, gv, done_data, req_pkt} = '0;
    out_ready = 1'b1;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    go(0, 40'h00_0000_1000, 0, 0, 0, 1);
    go(3, 40'h00_ffff_ffc0, 0, 0, 0, 1);
    go(4, 40'h01_0000_0000, 0, 0, 0, 0);
    go(0, 40'hfc_ffff_ffc0, 0, 0, 0, 0);
    go(5, 40'h00_0000_2000, 0, 0, 0, 1);
    go(0, 40'hfd_0000_0000, 0, 0, 1, 0);
    go(0, 40'hfd_f910_0000, 0, 0, 3, 0);
    go(2, 40'hfd_fc00_0000, 0, 0, 5, 0);
    go(2, 40'hfd_fe00_0004, 0, 0, 6, 0);
    go(0, 40'hfd_f920_0000, 0, 2, 4, 0);
    go(2, 40'hfe_0000_0000, 0, 3, 4, 0);
    go(2, 40'hfd_fe00_0000, 1, 3, 6, 0);
    go(0, 40'hfd_fc00_0000, 0, 1, 5, 0);
    go(3, 40'hfd_fe00_0000, 0, 1, 6, 0);
    go(1, 40'hfd_fe00_0000, 1, 1, 6, 0);
    go(1, 40'hfd_0000_0000, 0, 1, 1, 0);
    go(1, 40'hfd_f910_0000, 0, 1, 3, 0);
    go(0, 40'hfd_f900_0000, 0, 1, 2, 0);
    go(2, 40'hfd_f900_0000, 0, 1, 2, 0);
    // fill the posted queue with delivery stalled, then a read behind it
    out_ready <= 1'b0;
    fork
      begin
        repeat (6) go(0, {8'h00, $urandom}, 0, 0, 0, 1);
        go(2, {8'h00, $urandom}, 0, 0, 0, 1);
      end
      begin
        repeat (40) @(posedge clk);
        out_ready <= 1'b1;
      end
    join
    req_valid <= 1'b0;
    repeat (40) @(posedge clk);
    chk(ref_got, ref_exp);
    chk(drop_got, drop_exp);
    chk(q_pkt.size() + q_rsp.size(), 0);
    chk({np_busy, np_wait}, 2'b00);
    wrap_up();
  end
endmodule
